//--- inc/lamp_pkg.sv
package lamp_pkg;
   // Machine cycle and clock timing
   localparam int          CLK_PERIOD_NS    = 50;
   localparam int          MACHINE_CYCLE_NS = 1000;
   localparam int          MC_CLKS          = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0]  MC_LAST          = 5'(MC_CLKS - 1);
   localparam logic [4:0]  PRESCALE_RESET   = 5'h0_0;
   // Timebase
   localparam logic [7:0]  LOW_BYTE_RESET   = 8'h0_0;
   localparam logic [7:0]  HIGH_BYTE_RELOAD = 8'hF_0;
   localparam logic [7:0]  BYTE_ALL_ONES    = 8'hF_F;
   // Subdivider
   localparam logic [7:0]  SUB_RELOAD       = 8'hF_4;
   localparam logic [7:0]  SUB_ZERO         = 8'h0_0;
   localparam int          SLOW_BIT_POS     = 7;
   localparam int          FAST_BIT_POS     = 0;
   // Duty selection
   localparam logic [2:0]  DUTY_SQUARE      = 3'h0;
   localparam logic [3:0]  DUTY_FULL        = 4'h8;
endpackage

//--- inc/tick_if.sv
`timescale 1ns/100ps
interface tick_if;
   logic       tick;
   logic [7:0] sub_next;
   modport source (output tick, output sub_next);
   modport sink   (input  tick, input  sub_next);
endinterface

//--- design/timebase.sv
`timescale 1ns/100ps
module timebase (
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  timebase_run_i,
   input  wire logic  tick_event_enable_i,
   input  wire logic  global_event_enable_i,
   output logic [7:0] timebase_low_byte_o,
   output logic [7:0] timebase_high_byte_o,
   output logic [7:0] subdivider_o,
   tick_if.source     tk
);
   logic [4:0] prescale_reg;
   logic [7:0] low_reg;
   logic [7:0] high_reg;
   logic [7:0] sub_reg;
   logic [7:0] sub_next;
   logic       mc_step;
   logic       high_wrap;
   logic       tick;

   // ----------------------------------------
   // Machine cycle strobe
   // ----------------------------------------
   assign mc_step = timebase_run_i && (prescale_reg == lamp_pkg::MC_LAST);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prescale_reg <= lamp_pkg::PRESCALE_RESET;
      end else if (!timebase_run_i || mc_step) begin
         prescale_reg <= lamp_pkg::PRESCALE_RESET;
      end else begin
         prescale_reg <= prescale_reg + 5'h0_1;
      end
   end

   // ----------------------------------------
   // Sixteen-bit timebase
   // ----------------------------------------
   assign high_wrap = mc_step && (low_reg == lamp_pkg::BYTE_ALL_ONES)
                      && (high_reg == lamp_pkg::BYTE_ALL_ONES);
   assign tick      = high_wrap && tick_event_enable_i && global_event_enable_i; // [RULE4]

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_reg  <= lamp_pkg::LOW_BYTE_RESET;
         high_reg <= lamp_pkg::HIGH_BYTE_RELOAD;
      end else if (mc_step) begin
         low_reg <= low_reg + 8'h0_1; // [RULE2]
         if (low_reg == lamp_pkg::BYTE_ALL_ONES) begin
            // Reload on every wrap so spacing holds even with events masked
            if (high_reg == lamp_pkg::BYTE_ALL_ONES) begin
               high_reg <= lamp_pkg::HIGH_BYTE_RELOAD; // [RULE3]
            end else begin
               high_reg <= high_reg + 8'h0_1; // [RULE2]
            end
         end
      end
   end

   // ----------------------------------------
   // Subdivider
   // ----------------------------------------
   always_comb begin
      sub_next = sub_reg;
      if (tick) begin
         sub_next = sub_reg - 8'h0_1;
         if (sub_next == lamp_pkg::SUB_ZERO) begin
            sub_next = lamp_pkg::SUB_RELOAD; // [RULE5]
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sub_reg <= lamp_pkg::SUB_RELOAD; // [RULE5]
      end else begin
         sub_reg <= sub_next;
      end
   end

   assign timebase_low_byte_o  = low_reg;
   assign timebase_high_byte_o = high_reg;
   assign subdivider_o         = sub_reg;
   assign tk.tick              = tick;
   assign tk.sub_next          = sub_next;
endmodule // timebase

//--- design/turn_signal_lamp_controller.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - Switch inputs are active high
// RULE2 - Low byte per machine cycle, carries high
// RULE3 - High byte reloaded 0xF0 each tick
// RULE4 - Tick on high overflow when enabled
// RULE5 - Subdivider loads 244, decrements, reloads
// RULE6 - Subdivider bit 7 is slow blink
// RULE7 - Subdivider bit 0 is fast square
// RULE8 - Dim is parking AND fast square
// RULE9 - Left dash is (turn OR emergency) AND blink
// RULE10 - Left front is dash term OR dim
// RULE11 - Left rear steady on brake without turn
// RULE12 - Right side mirrors left side
// RULE13 - Lamps recomputed every tick
// RULE14 - Optional k/8 duty from bits 2..0
// RULE15 - Lamp registers update on tick, reset off
module turn_signal_lamp_controller (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       brake_i,
   input  wire logic       emergency_i,
   input  wire logic       parking_i,
   input  wire logic       left_turn_i,
   input  wire logic       right_turn_i,
   input  wire logic       timebase_run_i,
   input  wire logic       tick_event_enable_i,
   input  wire logic       global_event_enable_i,
   input  wire logic [2:0] duty_select_i,
   output logic            left_front_lamp_o,
   output logic            right_front_lamp_o,
   output logic            left_dash_lamp_o,
   output logic            right_dash_lamp_o,
   output logic            left_rear_lamp_o,
   output logic            right_rear_lamp_o,
   output logic            tick_o,
   output logic [7:0]      timebase_low_byte_o,
   output logic [7:0]      timebase_high_byte_o,
   output logic [7:0]      subdivider_o
);
   logic [4:0] sw_meta_reg;
   logic [4:0] sw_sync_reg;
   logic       brake;
   logic       emergency;
   logic       parking;
   logic       left_turn;
   logic       right_turn;
   logic       slow_blink_bit;
   logic       fast_square_bit;
   logic       duty_wave;
   logic       dim;
   logic       left_blink;
   logic       right_blink;
   logic [5:0] lamps_next;
   logic [5:0] lamps_reg;

   tick_if tk ();

   // ----------------------------------------
   // Timebase and subdivider
   // ----------------------------------------
   timebase u_timebase (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .timebase_run_i        (timebase_run_i),
      .tick_event_enable_i   (tick_event_enable_i),
      .global_event_enable_i (global_event_enable_i),
      .timebase_low_byte_o   (timebase_low_byte_o),
      .timebase_high_byte_o  (timebase_high_byte_o),
      .subdivider_o          (subdivider_o),
      .tk                    (tk.source)
   );

   // ----------------------------------------
   // Switch synchronisers
   // ----------------------------------------
   // Switches are asynchronous to the clock, so two stages first
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sw_meta_reg <= 5'h0_0;
         sw_sync_reg <= 5'h0_0;
      end else begin
         sw_meta_reg <= {right_turn_i, left_turn_i, parking_i, emergency_i, brake_i};
         sw_sync_reg <= sw_meta_reg;
      end
   end

   // High level means switch closed [RULE1]
   assign brake      = sw_sync_reg[0];
   assign emergency  = sw_sync_reg[1];
   assign parking    = sw_sync_reg[2];
   assign left_turn  = sw_sync_reg[3];
   assign right_turn = sw_sync_reg[4];

   // ----------------------------------------
   // Blink and dim terms
   // ----------------------------------------
   // Taken from the post-decrement value, as the lamps are computed after it
   assign slow_blink_bit  = tk.sub_next[lamp_pkg::SLOW_BIT_POS];  // [RULE6]
   assign fast_square_bit = tk.sub_next[lamp_pkg::FAST_BIT_POS];  // [RULE7]

   // Filament brightness is non-linear, hence the selectable duty
   always_comb begin
      if (duty_select_i == lamp_pkg::DUTY_SQUARE) begin
         duty_wave = fast_square_bit; // [RULE7]
      end else begin
         duty_wave = ({1'b0, tk.sub_next[2:0]} >= (lamp_pkg::DUTY_FULL - {1'b0, duty_select_i})); // [RULE14]
      end
   end

   assign dim         = parking && duty_wave;                          // [RULE8]
   assign left_blink  = (left_turn || emergency) && slow_blink_bit;    // [RULE9]
   assign right_blink = (right_turn || emergency) && slow_blink_bit;   // [RULE12]

   // ----------------------------------------
   // Lamp functions
   // ----------------------------------------
   always_comb begin
      lamps_next[0] = left_blink || dim;                                // [RULE10]
      lamps_next[1] = right_blink || dim;                               // [RULE12]
      lamps_next[2] = left_blink;                                       // [RULE9]
      lamps_next[3] = right_blink;                                      // [RULE12]
      lamps_next[4] = (brake && !left_turn) || left_blink || dim;       // [RULE11]
      lamps_next[5] = (brake && !right_turn) || right_blink || dim;     // [RULE12]
   end

   // All six change together, so no lamp ever leads another
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lamps_reg <= 6'h0_0; // [RULE15]
      end else if (tk.tick) begin
         lamps_reg <= lamps_next; // [RULE13] [RULE15]
      end
   end

   assign left_front_lamp_o  = lamps_reg[0];
   assign right_front_lamp_o = lamps_reg[1];
   assign left_dash_lamp_o   = lamps_reg[2];
   assign right_dash_lamp_o  = lamps_reg[3];
   assign left_rear_lamp_o   = lamps_reg[4];
   assign right_rear_lamp_o  = lamps_reg[5];
   assign tick_o             = tk.tick;
endmodule // turn_signal_lamp_controller

//--- test/switch_model.sv
`timescale 1ns/100ps
module switch_model (
   input  wire logic [4:0] pick_i,
   output logic      [4:0] switch_o
);
   // Closed switch reads as one: {brake, emergency, parking, left, right}
   assign switch_o = pick_i;
endmodule // switch_model

//--- test/lamp_chk.sv
`timescale 1ns/100ps
module lamp_chk (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       tick_event_enable_i,
   input wire logic       global_event_enable_i,
   input wire logic       left_front_lamp_o,
   input wire logic       right_front_lamp_o,
   input wire logic       left_dash_lamp_o,
   input wire logic       right_dash_lamp_o,
   input wire logic       left_rear_lamp_o,
   input wire logic       right_rear_lamp_o,
   input wire logic       tick_o,
   input wire logic [7:0] timebase_low_byte_o,
   input wire logic [7:0] timebase_high_byte_o,
   input wire logic [7:0] subdivider_o
);
   logic [5:0] lamps;
   assign lamps = {left_front_lamp_o, right_front_lamp_o, left_dash_lamp_o,
                   right_dash_lamp_o, left_rear_lamp_o, right_rear_lamp_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------
   // Timebase, subdivider and lamps
   // ----------------
   tick_wrap_a: assert property (tick_o |-> timebase_low_byte_o == 8'hFF &&
      timebase_high_byte_o == 8'hFF) else $error("tick without wrap");
   tick_gate_a: assert property (tick_o |-> tick_event_enable_i &&
      global_event_enable_i) else $error("tick while masked");
   high_reload_a: assert property (tick_o |=> timebase_high_byte_o == 8'hF0 &&
      timebase_low_byte_o == 8'h00) else $error("no reload after tick");
   low_step_a: assert property ($changed(timebase_low_byte_o) |->
      timebase_low_byte_o == $past(timebase_low_byte_o) + 8'h01) else $error("low skip");
   high_carry_a: assert property ($changed(timebase_high_byte_o) |->
      $past(timebase_low_byte_o) == 8'hFF) else $error("high moved without carry");
   sub_step_a: assert property (tick_o |=> subdivider_o == (($past(subdivider_o) == 8'h01) ?
      8'hF4 : $past(subdivider_o) - 8'h01)) else $error("subdivider step wrong");
   // Frozen state matters: a stray update shows as lamp jitter
   sub_hold_a: assert property (!tick_o |=> $stable(subdivider_o))
      else $error("subdivider moved");
   lamp_hold_a: assert property (!tick_o |=> $stable(lamps))
      else $error("lamps moved off tick");
   dash_blink_a: assert property (left_dash_lamp_o || right_dash_lamp_o |->
      subdivider_o[7]) else $error("dash lit with blink low");
   left_set_a: assert property (left_dash_lamp_o |-> left_front_lamp_o &&
      left_rear_lamp_o) else $error("left blink missing");
   right_set_a: assert property (right_dash_lamp_o |-> right_front_lamp_o &&
      right_rear_lamp_o) else $error("right blink missing");
   reset_off_a: assert property (disable iff (1'b0) rst_i |-> lamps == 6'h00 &&
      subdivider_o == 8'hF4) else $error("reset values wrong");
   cover property (tick_o);
   cover property (left_dash_lamp_o);
   cover property (right_rear_lamp_o && !right_dash_lamp_o);
endmodule // lamp_chk

bind turn_signal_lamp_controller lamp_chk u_lamp_chk (
   .clk_i, .rst_i, .tick_event_enable_i, .global_event_enable_i, .left_front_lamp_o,
   .right_front_lamp_o, .left_dash_lamp_o, .right_dash_lamp_o, .left_rear_lamp_o,
   .right_rear_lamp_o, .tick_o, .timebase_low_byte_o, .timebase_high_byte_o, .subdivider_o);

//--- test/tb_turn_signal_lamp_controller.sv
`timescale 1ns/100ps
module tb_turn_signal_lamp_controller;
   logic        clk_i, rst_i, timebase_run_i, tick_event_enable_i, global_event_enable_i;
   logic [4:0]  pick, sw;
   logic [2:0]  duty_select_i;
   logic        left_front_lamp_o, right_front_lamp_o, left_dash_lamp_o, tick_o;
   logic        right_dash_lamp_o, left_rear_lamp_o, right_rear_lamp_o;
   logic [7:0]  timebase_low_byte_o, timebase_high_byte_o, subdivider_o;
   logic        wave, dim, bl, br;
   logic [15:0] exp_q[$];
   int          fail_count, cmp_count, i;

   turn_signal_lamp_controller u_turn_signal_lamp_controller (
      .clk_i, .rst_i, .brake_i(sw[4]), .emergency_i(sw[3]), .parking_i(sw[2]),
      .left_turn_i(sw[1]), .right_turn_i(sw[0]), .timebase_run_i, .tick_event_enable_i,
      .global_event_enable_i, .duty_select_i, .left_front_lamp_o, .right_front_lamp_o,
      .left_dash_lamp_o, .right_dash_lamp_o, .left_rear_lamp_o, .right_rear_lamp_o, .tick_o,
      .timebase_low_byte_o, .timebase_high_byte_o, .subdivider_o);
   switch_model u_switch_model (.pick_i(pick), .switch_o(sw));

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         fail_count++;
         $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ----------------
   // Result watcher
   // ----------------
   initial begin
      forever begin
         @(posedge clk_i);
         #1;
         if (tick_o === 1'b1) begin
            // Tick is sampled 1 ns after the edge; lamps load at the edge that ends its cycle
            @(posedge clk_i);
            #1;
            if (exp_q.size() == 0) begin
               fail_count++;
            end else begin
               check({2'h0, left_front_lamp_o, right_front_lamp_o, left_dash_lamp_o,
                  right_dash_lamp_o, left_rear_lamp_o, right_rear_lamp_o, subdivider_o},
                  exp_q.pop_front());
            end
            check({timebase_low_byte_o, timebase_high_byte_o}, 16'h00F0);
         end
      end
   end

   // ----------------
   // Stimulus
   // ----------------
   initial begin
      rst_i = 1'b1;
      timebase_run_i = 1'b0;
      tick_event_enable_i = 1'b0;
      global_event_enable_i = 1'b0;
      duty_select_i = 3'h0;
      pick = 5'h00;
      void'($urandom(83));
      repeat (2) @(posedge clk_i);
      #1;
      check({2'h0, left_front_lamp_o, right_front_lamp_o, left_dash_lamp_o, right_dash_lamp_o,
         left_rear_lamp_o, right_rear_lamp_o, subdivider_o}, 16'h00F4);
      check({timebase_low_byte_o, timebase_high_byte_o}, 16'h00F0);
      // Only one tick fits the run, so the subdivider is 0xF3 when lamps load
      pick = {1'b1, 1'($urandom()), 1'b1, 1'b1, 1'b0};
      duty_select_i = 3'($urandom());
      wave = (duty_select_i == 3'h0) ? 1'b1 : (4'h3 >= 4'h8 - {1'b0, duty_select_i});
      dim = pick[2] & wave;
      bl = pick[1] | pick[3];
      br = pick[0] | pick[3];
      exp_q.push_back({2'h0, bl | dim, br | dim, bl, br, (pick[4] & ~pick[1]) | bl | dim,
         (pick[4] & ~pick[0]) | br | dim, 8'hF3});
      timebase_run_i = 1'b1;
      tick_event_enable_i = 1'b1;
      global_event_enable_i = 1'b1;
      rst_i = 1'b0;
      // Two machine cycles of 20 clocks pass in 45 clocks, then a pause freezes the count
      repeat (45) @(posedge clk_i);
      #1;
      timebase_run_i = 1'b0;
      repeat (30) @(posedge clk_i);
      #1;
      check({timebase_low_byte_o, timebase_high_byte_o}, 16'h02F0);
      timebase_run_i = 1'b1;
      for (i = 0; i < 90000 && tick_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      if (i == 90000) begin
         fail_count++;
      end
      repeat (2) @(posedge clk_i);
      #2;
      give_verdict();
   end
endmodule // tb_turn_signal_lamp_controller
